// File: bench/drive_state_control_tb.sv
// self-checking bench for the drive device-control state machine
`timescale 1ns/100ps
module drive_state_control_tb
	import dsc_pkg::*;
;
	logic        i_clk_sys;
	logic        i_rstn;
	logic        init_done;
	logic        fault;
	logic        decel_done;
	logic        auto_inhibit;
	logic        warning;
	logic        setpoint_reached;
	logic        limit_active;
	logic [15:0] ctrl_word;
	logic [15:0] o_status_word;
	logic        o_output_blocked;
	logic [31:0] seed = 32'hfdda;
	logic [17:0] q[$];
	logic [17:0] e;
	logic [16:0] got;
	int          errors = 0;
	int          comparisons = 0;

	////////////////////////////////////////////////////////////////////////////
	// clock at 40 MHz
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	dsc_plc_model plc_u (.i_clk_sys(i_clk_sys), .o_ctrl_word(ctrl_word));

	// every drive-side pin is driven so the mirror bits and auto inhibit are exercised
	dsc_device_ctrl dut_u (
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ctrl_word(ctrl_word),
		.i_init_done(init_done), .i_fault(fault), .i_decel_done(decel_done),
		.i_auto_inhibit(auto_inhibit), .i_warning(warning),
		.i_setpoint_reached(setpoint_reached),
		.i_limit_active(limit_active), .o_status_word(o_status_word),
		.o_output_blocked(o_output_blocked), .o_decel_req(), .o_state());

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// note format: bit 17 = blocked checked, bit 16 = blocked, 15..0 = status
	task automatic cmd(input int kind, input logic [15:0] m, input logic [17:0] x);
		plc_u.send(kind, xs() & m);
		@(posedge i_clk_sys);
		q.push_back(x);
	endtask : cmd

	// pin effects pass a synchroniser, so poll with a bound
	task automatic settle(input logic [17:0] x);
		int n;
		n = 0;
		while (o_status_word !== x[15:0] && n < 8) begin
			@(negedge i_clk_sys);
			n++;
		end
		if (o_status_word !== x[15:0]) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, o_status_word, x[15:0]);
			results();
		end
		@(posedge i_clk_sys);
		q.push_back(x);
	endtask : settle

	// watcher: compares the oldest note once outputs have settled
	always @(negedge i_clk_sys) begin
		if (q.size() > 0) begin
			e = q.pop_front();
			got = {o_output_blocked, o_status_word};
			if (!e[17])
				got[16] = e[16];
			comparisons++;
			if (got !== e[16:0])
				$display("wrong value at %0t: %h expected %h", $time, got, e[16:0]);
			if (got !== e[16:0])
				errors++;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_rstn = 1'b0;
		init_done = 1'b0;
		fault = 1'b0;
		decel_done = 1'b0;
		auto_inhibit = 1'b0;
		warning = 1'b0;
		setpoint_reached = 1'b0;
		limit_active = 1'b0;
		repeat (3) @(negedge i_clk_sys);
		i_rstn <= 1'b1;
		@(posedge i_clk_sys);
		q.push_back({2'b11, SW_NOT_READY});
		@(negedge i_clk_sys);
		init_done <= 1'b1;
		settle({2'b11, SW_INHIBITED});
		cmd(1, 16'hffff, {2'b11, SW_INHIBITED});
		cmd(0, 16'hffff, {2'b11, SW_READY});
		cmd(1, 16'hffff, {2'b11, SW_SWITCHED_ON});
		cmd(2, 16'hffff, {2'b10, SW_ENABLED});
		// automatic inhibit blocks the output while staying enabled; mirrors follow pins
		@(negedge i_clk_sys);
		auto_inhibit <= 1'b1;
		warning <= 1'b1;
		setpoint_reached <= 1'b1;
		limit_active <= 1'b1;
		settle({2'b11, SW_ENABLED | 16'h0d80});
		@(negedge i_clk_sys);
		auto_inhibit <= 1'b0;
		warning <= 1'b0;
		setpoint_reached <= 1'b0;
		limit_active <= 1'b0;
		settle({2'b10, SW_ENABLED});
		cmd(3, 16'hffff, {2'b11, SW_SWITCHED_ON});
		cmd(2, 16'hffff, {2'b10, SW_ENABLED});
		cmd(5, 16'hffff, {2'b00, SW_RAPID_STOP});
		@(negedge i_clk_sys);
		decel_done <= 1'b1;
		settle({2'b11, SW_INHIBITED});
		@(negedge i_clk_sys);
		decel_done <= 1'b0;
		cmd(0, 16'hffff, {2'b11, SW_READY});
		cmd(1, 16'hffff, {2'b11, SW_SWITCHED_ON});
		cmd(2, 16'hffff, {2'b10, SW_ENABLED});
		cmd(4, 16'hfffb, {2'b11, SW_INHIBITED});
		cmd(0, 16'hffff, {2'b11, SW_READY});
		cmd(5, 16'hffff, {2'b11, SW_INHIBITED});
		@(negedge i_clk_sys);
		fault <= 1'b1;
		settle({2'b00, SW_TRIP_REACT});
		@(negedge i_clk_sys);
		decel_done <= 1'b1;
		settle({2'b00, SW_TRIP});
		@(negedge i_clk_sys);
		decel_done <= 1'b0;
		cmd(6, 16'hffff, {2'b00, SW_TRIP});
		@(negedge i_clk_sys);
		fault <= 1'b0;
		repeat (3) @(negedge i_clk_sys);
		cmd(6, 16'hffff, {2'b00, SW_TRIP});
		cmd(0, 16'hffff, {2'b00, SW_TRIP});
		cmd(6, 16'hffff, {2'b11, SW_INHIBITED});
		@(negedge i_clk_sys);
		results();
	end
endmodule : drive_state_control_tb

// File: bench/dsc_plc_model.sv
// fieldbus master model: builds control words from command patterns
`timescale 1ns/100ps
module dsc_plc_model
	import dsc_pkg::*;
(
	// clock
	input  wire logic        i_clk_sys,
	// control word towards the drive
	output logic [15:0]      o_ctrl_word
);
	////////////////////////////////////////////////////////////////////////////
	// kinds: shut down, switch on, enable, inhibit op, inhibit volt, rapid stop, trip reset
	localparam logic [15:0] PAT [0:6] = '{16'h0006, 16'h0007, 16'h000f, 16'h0007,
		16'h0000, 16'h0002, 16'h0080};
	localparam logic [15:0] MSK [0:6] = '{16'h0007, 16'h0007, 16'h000f, 16'h000f,
		16'h0002, 16'h0006, 16'h00ff};

	initial o_ctrl_word = 16'h0000;

	// free bits carry filler; bit 7 stays low so only trip reset makes an edge
	task automatic send(input int kind, input logic [15:0] fill);
		@(negedge i_clk_sys);
		o_ctrl_word <= (PAT[kind] & MSK[kind]) | (fill & ~MSK[kind] & 16'hff7f);
	endtask : send
endmodule : dsc_plc_model

// File: include/dsc_pkg.sv
// package: drive state control constants, state encoding and carrier structs
package dsc_pkg;

	// control word bit positions
	localparam int CW_SWITCH_ON  = 0;
	localparam int CW_VOLTAGE    = 1;
	localparam int CW_RAPID_STOP = 2;
	localparam int CW_ENABLE_OP  = 3;
	localparam int CW_TRIP_RESET = 7;

	// status word bit positions
	localparam int SW_WARNING    = 7;
	localparam int SW_MESSAGE    = 8;
	localparam int SW_SETPOINT   = 10;
	localparam int SW_LIMIT      = 11;

	// status word state patterns (bits 6,5 and 3..0; bit 4 left clear)
	localparam logic [15:0] SW_NOT_READY   = 16'h0000;
	localparam logic [15:0] SW_INHIBITED   = 16'h0040;
	localparam logic [15:0] SW_READY       = 16'h0021;
	localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
	localparam logic [15:0] SW_ENABLED     = 16'h0027;
	localparam logic [15:0] SW_TRIP        = 16'h0008;
	localparam logic [15:0] SW_TRIP_REACT  = 16'h000f;
	localparam logic [15:0] SW_RAPID_STOP  = 16'h0007;

	// reset values
	localparam logic        RST_OUTPUT_BLOCKED = 1'b1;
	localparam logic        RST_PREV_RESET_BIT = 1'b0;

	// device states, gray along the usual power-up path
	typedef enum logic [2:0] {
		DSC_NOT_READY   = 3'h0,
		DSC_INHIBITED   = 3'h1,
		DSC_READY       = 3'h3,
		DSC_SWITCHED_ON = 3'h2,
		DSC_ENABLED     = 3'h6,
		DSC_RAPID_STOP  = 3'h7,
		DSC_TRIP_REACT  = 3'h5,
		DSC_TRIP        = 3'h4
	} dsc_state_t;

	// decoded control word requests
	typedef struct packed {
		logic shut_down;
		logic switch_on;
		logic enable_op;
		logic inhibit_op;
		logic inhibit_volt;
		logic rapid_stop;
		logic trip_reset;
	} dsc_req_t;

	// drive-side conditions, all synchronised
	typedef struct packed {
		logic init_done;
		logic fault;
		logic decel_done;
		logic auto_inhibit;
		logic warning;
		logic setpoint_reached;
		logic limit_active;
	} dsc_drive_t;

endpackage : dsc_pkg

// File: src/dsc_cmd_decode.sv
// control word decoder: combinational command patterns and trip-reset edge
`timescale 1ns/100ps
module dsc_cmd_decode
	import dsc_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// control word from the fieldbus side, already in the clock domain
	input  wire logic [15:0] i_ctrl_word,
	// decoded requests
	output dsc_req_t         o_req
);

	logic prev_reset_bit;

	// each command only looks at the bits it defines, the rest are don't care
	wire b0 = i_ctrl_word[CW_SWITCH_ON];
	wire b1 = i_ctrl_word[CW_VOLTAGE];
	wire b2 = i_ctrl_word[CW_RAPID_STOP];
	wire b3 = i_ctrl_word[CW_ENABLE_OP];
	wire b7 = i_ctrl_word[CW_TRIP_RESET];

	assign o_req.shut_down    = ~b0 & b1 & b2;
	assign o_req.switch_on    = b0 & b1 & b2;
	assign o_req.enable_op    = b3 & b2 & b1 & b0;
	assign o_req.inhibit_op   = ~b3 & b2 & b1 & b0;
	assign o_req.inhibit_volt = ~b1;
	assign o_req.rapid_stop   = ~b2 & b1;
	assign o_req.trip_reset   = b7 & ~prev_reset_bit;

	// previous bit 7 kept so a static high level never retriggers a reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			prev_reset_bit <= RST_PREV_RESET_BIT;
		end else begin
			prev_reset_bit <= b7;
		end
	end

	chk_reset_edge_only: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_req.trip_reset |-> (b7 && !$past(b7)))
		else $error("trip reset decoded without a rising edge");

endmodule : dsc_cmd_decode

// File: src/dsc_device_ctrl.sv
// drive device-control state machine with status word generation
`timescale 1ns/100ps
module dsc_device_ctrl
	import dsc_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// control word, from logic on the same clock
	input  wire logic [15:0] i_ctrl_word,
	// drive-side conditions, pins from outside the clock domain
	input  wire logic        i_init_done,
	input  wire logic        i_fault,
	input  wire logic        i_decel_done,
	input  wire logic        i_auto_inhibit,
	input  wire logic        i_warning,
	input  wire logic        i_setpoint_reached,
	input  wire logic        i_limit_active,
	// status and control outputs
	output logic [15:0]      o_status_word,
	output logic             o_output_blocked,
	output logic             o_decel_req,
	output logic [2:0]       o_state
);

	//////////////////////////////////////////////////////////////////////////////

	dsc_drive_t  drv_meta;
	dsc_drive_t  drv;
	dsc_req_t    req;
	dsc_state_t  state;
	dsc_state_t  next_state;
	logic [15:0] next_status;
	logic        next_blocked;
	logic        next_decel;

	// two stages on every pin input; only the second stage is read
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			drv_meta <= '0;
			drv      <= '0;
		end else begin
			drv_meta <= {i_init_done, i_fault, i_decel_done, i_auto_inhibit,
				i_warning, i_setpoint_reached, i_limit_active};
			drv      <= drv_meta;
		end
	end

	dsc_cmd_decode u_decode (
		.i_clk_sys   (i_clk_sys),
		.i_rstn      (i_rstn),
		.i_ctrl_word (i_ctrl_word),
		.o_req       (req)
	);

	//////////////////////////////////////////////////////////////////////////////

	// state pattern lookup used for both next status and checks
	function automatic logic [15:0] state_bits(input dsc_state_t s);
		unique case (s)
			DSC_NOT_READY:   state_bits = SW_NOT_READY;
			DSC_INHIBITED:   state_bits = SW_INHIBITED;
			DSC_READY:       state_bits = SW_READY;
			DSC_SWITCHED_ON: state_bits = SW_SWITCHED_ON;
			DSC_ENABLED:     state_bits = SW_ENABLED;
			DSC_RAPID_STOP:  state_bits = SW_RAPID_STOP;
			DSC_TRIP_REACT:  state_bits = SW_TRIP_REACT;
			DSC_TRIP:        state_bits = SW_TRIP;
		endcase
	endfunction : state_bits

	// precedence: fault, then inhibit voltage, then rapid stop, then the rest
	wire go_fault   = drv.fault && state != DSC_TRIP_REACT && state != DSC_TRIP;
	wire go_inhvolt = req.inhibit_volt;
	wire go_rstop   = req.rapid_stop && !req.inhibit_volt;

	// transition selection; a command with no edge from here changes nothing
	always_comb begin
		next_state = state;
		if (go_fault) begin
			next_state = DSC_TRIP_REACT;
		end else begin
			unique case (state)
				DSC_NOT_READY: begin
					if (drv.init_done)
						next_state = DSC_INHIBITED;
				end
				DSC_INHIBITED: begin
					if (!go_inhvolt && !go_rstop && req.shut_down)
						next_state = DSC_READY;
				end
				DSC_READY: begin
					if (go_inhvolt || go_rstop)
						next_state = DSC_INHIBITED;
					else if (req.switch_on)
						next_state = DSC_SWITCHED_ON;
				end
				DSC_SWITCHED_ON: begin
					if (go_inhvolt || go_rstop)
						next_state = DSC_INHIBITED;
					else if (req.shut_down)
						next_state = DSC_READY;
					else if (req.enable_op)
						next_state = DSC_ENABLED;
				end
				DSC_ENABLED: begin
					if (go_inhvolt)
						next_state = DSC_INHIBITED;
					else if (go_rstop)
						next_state = DSC_RAPID_STOP;
					else if (req.shut_down)
						next_state = DSC_READY;
					else if (req.inhibit_op)
						next_state = DSC_SWITCHED_ON;
				end
				DSC_RAPID_STOP: begin
					// inhibiting voltage cuts the ramp short
					if (go_inhvolt || drv.decel_done)
						next_state = DSC_INHIBITED;
				end
				DSC_TRIP_REACT: begin
					if (drv.decel_done)
						next_state = DSC_TRIP;
				end
				DSC_TRIP: begin
					if (req.trip_reset && !drv.fault)
						next_state = DSC_INHIBITED;
				end
			endcase
		end
	end

	// outputs follow the next state so they line up with the state register
	always_comb begin
		next_status = state_bits(next_state);
		next_status[SW_WARNING]  = drv.warning;
		next_status[SW_SETPOINT] = drv.setpoint_reached;
		next_status[SW_LIMIT]    = drv.limit_active;
		next_status[SW_MESSAGE]  = next_state == DSC_ENABLED && drv.auto_inhibit;
		next_blocked = !(next_state == DSC_ENABLED && !drv.auto_inhibit);
		next_decel   = next_state == DSC_RAPID_STOP || next_state == DSC_TRIP_REACT;
	end

	// state register and registered outputs
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			state            <= DSC_NOT_READY;
			o_status_word    <= SW_NOT_READY;
			o_output_blocked <= RST_OUTPUT_BLOCKED;
			o_decel_req      <= 1'b0;
			o_state          <= DSC_NOT_READY;
		end else begin
			state            <= next_state;
			o_status_word    <= next_status;
			o_output_blocked <= next_blocked;
			o_decel_req      <= next_decel;
			o_state          <= next_state;
		end
	end

	//////////////////////////////////////////////////////////////////////////////

	sequence s_trip_seen;
		state == DSC_TRIP && req.trip_reset && !drv.fault;
	endsequence

	chk_fault_trip_react: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		go_fault |=> state == DSC_TRIP_REACT)
		else $error("fault did not enter trip reaction");

	chk_react_to_trip: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state == DSC_TRIP_REACT && drv.decel_done && !drv.fault) |=> state == DSC_TRIP)
		else $error("trip reaction did not finish into trip");

	chk_reset_clears_trip: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		s_trip_seen |=> state == DSC_INHIBITED)
		else $error("trip reset did not reach switch-on inhibited");

	chk_trip_held_fault: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state == DSC_TRIP && drv.fault) |=> state == DSC_TRIP)
		else $error("trip left while fault present");

	chk_status_pattern: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(o_status_word & 16'h006f) == state_bits(state))
		else $error("status word does not match state");

	chk_voltage_first: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state inside {DSC_READY, DSC_SWITCHED_ON, DSC_ENABLED} && req.inhibit_volt
		 && !go_fault) |=> state == DSC_INHIBITED)
		else $error("inhibit voltage lost priority");

	chk_rapid_ramp: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state == DSC_ENABLED && go_rstop && !go_fault) |=> o_decel_req && !o_status_word[5])
		else $error("rapid stop from enabled did not ramp");

	chk_blocked_off_en: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state != DSC_ENABLED) |-> o_output_blocked)
		else $error("output released outside enabled");

	chk_init_leaves: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state == DSC_NOT_READY && drv.init_done && !drv.fault) |=> state == DSC_INHIBITED)
		else $error("did not leave not-ready after init");

	// pin mirrors land one edge after the synchronised value is seen
	chk_warning_mirror: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_status_word[SW_WARNING] == $past(drv.warning))
		else $error("warning bit does not follow its pin");

	chk_ignored_cmd: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state == DSC_INHIBITED && !req.shut_down && !go_fault) |=> $stable(state))
		else $error("state moved without a valid command");

endmodule : dsc_device_ctrl
